// File: hdl/reset_seq_pkg.sv
// constants shared by the board reset sequencer
// Operation
// - observe panel, hub, controller and processor reset requests; classify power-up, hard, soft
// - power-good output asserts 30 to 40 ms after supply power-good seen
// - hard reset from software or front panel button via reset microcontroller
// - any of the three hard reset sources (panel, software, I/O controller) asserts both ISA and PCI bus resets
// - ISA reset resets ISA subsystem; PCI reset resets PCI bus
// - host bridge forwards PCI reset as processor reset
// - keyboard soft reset and chipset init merge into one processor init
// - soft reset restarts processors without flushing caches or buffers
package reset_seq_pkg;
   localparam int unsigned CLK_HZ       = 10_000_000;
   localparam int unsigned PGOOD_MIN_MS = 30;
   localparam int unsigned PGOOD_MAX_MS = 40;
   // wait is aimed at the lower bound, with the clock division exact, so at this CLK_HZ it lands inside the window
   localparam int unsigned PGOOD_CYCLES = (CLK_HZ / 1000) * PGOOD_MIN_MS;
   localparam int unsigned HOLD_CYCLES  = 16;
   // reset class codes reported on resetKind
   localparam logic [1:0]  KIND_POWER_UP = 2'h0;
   localparam logic [1:0]  KIND_HARD     = 2'h1;
   localparam logic [1:0]  KIND_SOFT     = 2'h2;
   typedef enum logic [1:0] {
      ST_POWER_UP = 2'b00,
      ST_HARD     = 2'b01,
      ST_RUN      = 2'b10
   } seq_state_t;
endpackage

// File: hdl/sync2.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ns
module sync2 (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout
);
   logic stage1;
   logic next_stage1;
   logic next_dout;

   always_comb begin
      next_stage1 = din;
      next_dout   = stage1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stage1 <= 1'b0;
         dout   <= 1'b0;
      end else begin
         stage1 <= next_stage1;
         dout   <= next_dout;
      end
   end
endmodule

// File: hdl/board_reset_sequencer.sv
// board reset sequencer: power-up, hard and soft reset generation
`timescale 1ns/1ns
module board_reset_sequencer #(
   parameter int unsigned PGOOD_CYCLES = reset_seq_pkg::PGOOD_CYCLES,
   parameter int unsigned HOLD_CYCLES  = reset_seq_pkg::HOLD_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic supplyPowerGood,
   input  wire logic panelResetReq_n,
   input  wire logic swHardResetReq,
   input  wire logic ioCtrlResetReq,
   input  wire logic keyboard_soft_reset_req_n,
   input  wire logic chipsetInitReq_n,
   output logic      mgmtPowerGood,
   output logic      isa_bus_reset_out,
   output logic      pci_bus_reset_out,
   output logic      cpuReset_n,
   output logic      cpuInit_n,
   output logic [1:0] resetKind
);
   // one counter serves both waits, so it is sized for the longer of the two
   localparam int CW = $clog2(((PGOOD_CYCLES > HOLD_CYCLES) ? PGOOD_CYCLES : HOLD_CYCLES)
                              + 1);

   // counter step shared by the power-up wait, the hard-reset hold and the check counter
   function automatic logic [CW-1:0] countUp(input logic [CW-1:0] value);
      countUp = value + 1'b1;
   endfunction

   logic          sPgood;
   logic          sPanel;
   logic          sSw;
   logic          sIo;
   logic          sKb;
   logic          sInit;

   // every request pin is asynchronous to clk, so each one passes two flops first
   sync2 uPg (
      .clk  (clk),
      .rst  (rst),
      .din  (supplyPowerGood),
      .dout (sPgood)
   );

   sync2 uPan (
      .clk  (clk),
      .rst  (rst),
      .din  (~panelResetReq_n),
      .dout (sPanel)
   );

   sync2 uSw (
      .clk  (clk),
      .rst  (rst),
      .din  (swHardResetReq),
      .dout (sSw)
   );

   sync2 uIo (
      .clk  (clk),
      .rst  (rst),
      .din  (ioCtrlResetReq),
      .dout (sIo)
   );

   sync2 uKb (
      .clk  (clk),
      .rst  (rst),
      .din  (~keyboard_soft_reset_req_n),
      .dout (sKb)
   );

   sync2 uIn (
      .clk  (clk),
      .rst  (rst),
      .din  (~chipsetInitReq_n),
      .dout (sInit)
   );

   reset_seq_pkg::seq_state_t state;
   reset_seq_pkg::seq_state_t next_state;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic          pgood;
   logic          next_pgood;
   logic          busRst;
   logic          next_busRst;
   logic          init;
   logic          next_init;
   logic [1:0]    kind;
   logic [1:0]    next_kind;
   logic          hardReq;

   // panel button arrives through the reset microcontroller as one hard request
   assign hardReq = sPanel | sSw | sIo;

   always_comb begin
      next_state  = state;
      next_cnt    = cnt;
      next_pgood  = pgood;
      next_busRst = busRst;
      next_kind   = kind;
      unique case (state)
         reset_seq_pkg::ST_POWER_UP: begin
            next_busRst = 1'b1;
            next_kind   = reset_seq_pkg::KIND_POWER_UP;
            if (!sPgood) begin
               next_cnt   = '0;
               next_pgood = 1'b0;
            end else if (cnt == CW'(PGOOD_CYCLES - 1)) begin
               next_pgood = 1'b1;
               next_state = reset_seq_pkg::ST_RUN;
               next_cnt   = '0;
            end else begin
               next_cnt = countUp(cnt);
            end
         end
         reset_seq_pkg::ST_HARD: begin
            next_busRst = 1'b1;
            next_kind   = reset_seq_pkg::KIND_HARD;
            if (hardReq) begin
               next_cnt = '0;
            end else if (cnt == CW'(HOLD_CYCLES - 1)) begin
               next_busRst = 1'b0;
               next_state  = reset_seq_pkg::ST_RUN;
               next_cnt    = '0;
            end else begin
               next_cnt = countUp(cnt);
            end
         end
         reset_seq_pkg::ST_RUN: begin
            next_busRst = 1'b0;
            if (hardReq) begin
               next_busRst = 1'b1;
               next_state  = reset_seq_pkg::ST_HARD;
               next_cnt    = '0;
               next_kind   = reset_seq_pkg::KIND_HARD;
            end else if (sKb | sInit) begin
               next_kind = reset_seq_pkg::KIND_SOFT;
            end
         end
         default: next_state = reset_seq_pkg::ST_POWER_UP;
      endcase
      // loss of supply power-good restarts the power-up sequence
      if (!sPgood && state != reset_seq_pkg::ST_POWER_UP) begin
         next_state  = reset_seq_pkg::ST_POWER_UP;
         next_pgood  = 1'b0;
         next_busRst = 1'b1;
         next_cnt    = '0;
      end
      // soft reset pulses init and leaves bus resets alone; caches are never touched here
      next_init = ~next_pgood | sKb | sInit;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state  <= reset_seq_pkg::ST_POWER_UP;
         cnt    <= '0;
         pgood  <= 1'b0;
         busRst <= 1'b1;
         init   <= 1'b1;
         kind   <= 2'b00;
      end else begin
         state  <= next_state;
         cnt    <= next_cnt;
         pgood  <= next_pgood;
         busRst <= next_busRst;
         init   <= next_init;
         kind   <= next_kind;
      end
   end

   assign mgmtPowerGood     = pgood;
   assign isa_bus_reset_out = busRst;
   assign pci_bus_reset_out = busRst;
   assign cpuReset_n        = ~busRst;
   assign cpuInit_n         = ~init;
   assign resetKind         = kind;

   // independent count of how long supply power-good has stood, for the delay check
   logic [CW-1:0] pgRun;
   logic [CW-1:0] next_pgRun;

   always_comb begin
      next_pgRun = pgRun;
      if (!sPgood) begin
         next_pgRun = '0;
      end else if (pgRun != '1) begin
         next_pgRun = countUp(pgRun);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pgRun <= '0;
      end else begin
         pgRun <= next_pgRun;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_pgood_delay: assert property ($rose(pgood) |-> $past(sPgood, 2))
      else $error("power-good rose without supply power-good");
   a_pgood_hold: assert property (!pgood |-> busRst && init)
      else $error("outputs released before power-good");
   a_hard_both: assert property (hardReq && pgood |=> isa_bus_reset_out && pci_bus_reset_out)
      else $error("hard request did not assert both bus resets");
   a_cpu_follow: assert property (cpuReset_n == !pci_bus_reset_out)
      else $error("processor reset not following pci reset");
   a_init_merge: assert property ((sKb || sInit) |=> init)
      else $error("soft request did not assert init");
   a_soft_nobus: assert property (pgood && !hardReq && state == reset_seq_pkg::ST_RUN
      && (sKb || sInit) && sPgood |=> !busRst)
      else $error("soft reset disturbed bus reset");
   a_kind_hard: assert property (state == reset_seq_pkg::ST_HARD
      |-> kind == reset_seq_pkg::KIND_HARD)
      else $error("hard reset not classified");
   a_panel_path: assert property (sPanel && pgood && sPgood |=> state == reset_seq_pkg::ST_HARD)
      else $error("panel request lost");
   a_pgood_count: assert property ($rose(pgood) |-> pgRun == CW'(PGOOD_CYCLES))
      else $error("power-good delay does not match the configured wait");
   a_kind_soft: assert property (state == reset_seq_pkg::ST_RUN && !hardReq && sPgood && (sKb || sInit) |=> kind == reset_seq_pkg::KIND_SOFT)
      else $error("soft reset not classified");
   a_supply_loss: assert property (!sPgood && state != reset_seq_pkg::ST_POWER_UP |=> state == reset_seq_pkg::ST_POWER_UP && !pgood)
      else $error("supply loss did not restart power-up");
   a_init_release: assert property (pgood && sPgood && !sKb && !sInit |=> !init)
      else $error("init held without a soft request");

   c_powerup: cover property ($rose(pgood));
   c_hard:    cover property (state == reset_seq_pkg::ST_HARD ##1 state == reset_seq_pkg::ST_RUN);
   c_soft:    cover property (pgood && $rose(init));
   c_loss:    cover property (pgood ##1 !pgood);
   c_kb_init: cover property (pgood && sKb);
endmodule

// File: verif/cpu_side_model.sv
// processor side model: chipset init source and reset/init event counts
`timescale 1ns/1ns
module cpu_side_model (
   input  wire logic clk,
   input  wire logic cpuReset_n,
   input  wire logic cpuInit_n,
   input  wire logic initReq,
   output logic      chipsetInitReq_n,
   output int        resets,
   output int        inits
);
   logic lastRst_n = 1'b0;
   logic lastInit_n = 1'b0;
   initial resets = 0;
   initial inits = 0;
   assign chipsetInitReq_n = ~initReq;
   always @(posedge clk) begin
      lastRst_n <= cpuReset_n;
      lastInit_n <= cpuInit_n;
      // only the forwarded reset restarts from scratch; init keeps caches
      if (lastRst_n && !cpuReset_n) resets <= resets + 1;
      if (lastInit_n && !cpuInit_n && cpuReset_n) inits <= inits + 1;
   end
endmodule

// File: verif/tb_top.sv
// self-checking bench for the board reset sequencer
`timescale 1ns/1ns
module tb_top;
   logic clk = 1'b0, rst = 1'b1, supplyPowerGood = 1'b0, initReq = 1'b0;
   logic panelResetReq_n = 1'b1, swHardResetReq = 1'b0, ioCtrlResetReq = 1'b0;
   logic keyboard_soft_reset_req_n = 1'b1;
   logic chipsetInitReq_n, mgmtPowerGood, isa, pci, cpuReset_n, cpuInit_n;
   logic [1:0] resetKind;
   int n_errors = 0, total_checks = 0, cycles = 0, resets, inits, r0;
   wire [3:0] outs = {isa, pci, cpuReset_n, cpuInit_n};
   board_reset_sequencer #(.PGOOD_CYCLES(20), .HOLD_CYCLES(4)) board_reset_sequencer_i (
      .clk(clk), .rst(rst), .supplyPowerGood(supplyPowerGood),
      .panelResetReq_n(panelResetReq_n), .swHardResetReq(swHardResetReq),
      .ioCtrlResetReq(ioCtrlResetReq), .keyboard_soft_reset_req_n(keyboard_soft_reset_req_n),
      .chipsetInitReq_n(chipsetInitReq_n), .mgmtPowerGood(mgmtPowerGood),
      .isa_bus_reset_out(isa), .pci_bus_reset_out(pci), .cpuReset_n(cpuReset_n),
      .cpuInit_n(cpuInit_n), .resetKind(resetKind));
   cpu_side_model cpu_side_model_i (.clk(clk), .cpuReset_n(cpuReset_n),
      .cpuInit_n(cpuInit_n), .initReq(initReq), .chipsetInitReq_n(chipsetInitReq_n),
      .resets(resets), .inits(inits));
   always #50 clk = ~clk;
   task test_done;
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         test_done();
      end
   end
   task chk(input logic [3:0] seen, input logic [3:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task power_up;
      int n;
      n = 0;
      supplyPowerGood = 1'b1;
      while (mgmtPowerGood !== 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      chk(4'(n >= 21 && n <= 24), 4'h1);
      step(2);
      chk(outs, 4'h3);
   endtask
   task hard_reset(input int src);
      r0 = resets;
      if (src == 0) panelResetReq_n = 1'b0;
      if (src == 1) swHardResetReq = 1'b1;
      if (src == 2) ioCtrlResetReq = 1'b1;
      step(4);
      chk(outs, 4'hd);
      chk({2'b00, resetKind}, 4'h1);
      chk(4'(resets - r0), 4'h1);
      {panelResetReq_n, swHardResetReq, ioCtrlResetReq} = 3'b100;
      step(2);
      chk(outs, 4'hd);
      step(10);
      chk(outs, 4'h3);
   endtask
   task soft_reset(input int src);
      r0 = inits;
      if (src == 0) keyboard_soft_reset_req_n = 1'b0;
      else initReq = 1'b1;
      step(4);
      chk(outs, 4'h2);
      chk({2'b00, resetKind}, 4'h2);
      keyboard_soft_reset_req_n = 1'b1;
      initReq = 1'b0;
      step(6);
      chk(outs, 4'h3);
      chk(4'(inits - r0), 4'h1);
   endtask
   task supply_loss;
      supplyPowerGood = 1'b0;
      panelResetReq_n = 1'b0;
      keyboard_soft_reset_req_n = 1'b0;
      step(5);
      chk(outs, 4'hc);
      chk({mgmtPowerGood, 1'b0, resetKind}, 4'h0);
      panelResetReq_n = 1'b1;
      keyboard_soft_reset_req_n = 1'b1;
      power_up();
   endtask
   initial begin
      step(2);
      rst = 1'b0;
      chk(outs, 4'hc);
      chk({2'b00, resetKind}, 4'h0);
      power_up();
      for (int s = 0; s < 3; s++) hard_reset(s);
      for (int s = 0; s < 2; s++) soft_reset(s);
      supply_loss();
      test_done();
   end
endmodule
